// ===== core/vcc_pkg.sv
// Constants shared by the comparator control logic.
// Assumes the core clock is much faster than the low-speed time-base clock.
//
// Behaviour
// - Any control register write starts a comparison.
// - Result latched six base clock cycles later.
// - Comparison ends when result latches; then idle.
// - Result is 1 when input above reference.
// - Result reads at bit 0 of control.
// - Early or unstarted reads return previous result.
// - Result reads 0 after reset until completion.
// - Control register resets to value 0EH.
package vcc_pkg;

  // Width of the control register.
  localparam int unsigned CMP_REG_W = 4;

  // Bit position of the comparison result.
  localparam int unsigned CMP_RESULT_BIT = 0;

  // Value of the control register after system reset.
  localparam logic [CMP_REG_W-1:0] CMP_RESET_VALUE = 4'hE;

  // Upper bits of the control register, which always read as ones.
  localparam logic [CMP_REG_W-2:0] CMP_UPPER_BITS = 3'h7;

  // Length of the comparison window in low-speed base clock cycles.
  localparam int unsigned CMP_WINDOW_TICKS = 6;

  // Width of the window tick counter.
  localparam int unsigned CMP_CNT_W = 3;

  // Depth of the input synchroniser.
  localparam int unsigned CMP_SYNC_STAGES = 2;

  // Controller states, one-hot.
  typedef enum logic [1:0] {
    VCC_IDLE = 2'h1,
    VCC_RUN  = 2'h2
  } vcc_state_e;

endpackage

// ===== core/vcc_sync.sv
// Two-flop synchroniser for signals arriving from outside the core clock domain.
// Assumes each bit is a level that is stable for several core clock cycles.
`timescale 1ns/1ns
module vcc_sync #(
  parameter int unsigned WIDTH = 1
) (
  // Clock and reset.
  input  wire logic             clk,
  input  wire logic             rst,
  // Asynchronous input and synchronised output.
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_reg;

  // The first stage is read only by the second stage.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_reg <= '0;
      sync_out <= '0;
    end else begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule

// ===== core/vcc_top.sv
// Control logic of the on-chip voltage comparator.
// Assumes the CPU gives one-cycle pre-decoded read and write strobes on CORE_CLK,
// and that the low-speed base clock and analog decision arrive asynchronously.
`timescale 1ns/1ns
module vcc_top
  import vcc_pkg::*;
#(
  parameter int unsigned WINDOW_TICKS = vcc_pkg::CMP_WINDOW_TICKS
) (
  // Clock and reset.
  input  wire logic                          CORE_CLK,
  input  wire logic                          RESET,
  // Control register access from the CPU.
  input  wire logic                          CTRL_WR_STB,
  input  wire logic [vcc_pkg::CMP_REG_W-1:0] CTRL_WDATA,
  input  wire logic                          CTRL_RD_STB,
  output logic      [vcc_pkg::CMP_REG_W-1:0] CTRL_RDATA,
  // Low-speed time-base clock, sampled as a level.
  input  wire logic                          LOW_SPEED_BASE_CLK,
  // Analog comparator stage.
  input  wire logic                          COMPARE_DECISION,
  output logic                               COMPARE_ENABLE
);

  import vcc_pkg::*;

  localparam logic [CMP_CNT_W-1:0] LAST_TICK = CMP_CNT_W'(WINDOW_TICKS - 1);

  vcc_state_e           state_reg;
  vcc_state_e           state_next;
  logic [CMP_CNT_W-1:0] tick_cnt_reg;
  logic [CMP_CNT_W-1:0] tick_cnt_next;
  logic                 result_reg;
  logic                 result_next;
  logic [1:0]           sync_bits;
  logic                 base_clk_s;
  logic                 decision_s;
  logic                 base_clk_d_reg;
  logic                 tick;
  logic                 finish;
  logic                 unused_inputs;

  // The written value and the read strobe have no effect on the logic.
  assign unused_inputs = CTRL_RD_STB ^ (^CTRL_WDATA);

  // Both outside signals pass two flip-flops before any logic reads them.
  vcc_sync #(
    .WIDTH (2)
  ) u_sync (
    .clk      (CORE_CLK),
    .rst      (RESET),
    .async_in ({LOW_SPEED_BASE_CLK, COMPARE_DECISION}),
    .sync_out (sync_bits)
  );

  assign base_clk_s = sync_bits[1];
  assign decision_s = sync_bits[0];

  // Delayed copy of the synchronised base clock for edge detection.
  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      base_clk_d_reg <= 1'b0;
    end else begin
      base_clk_d_reg <= base_clk_s;
    end
  end

  // Arming chain for the edge detector, one stage per synchroniser flop and one for the copy.
  logic [CMP_SYNC_STAGES:0] arm_reg;

  // Tick detection waits until the synchroniser and the delayed copy hold real pin levels,
  // so a base clock that is already high at reset release is not taken for a rising edge.
  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      arm_reg <= '0;
    end else begin
      arm_reg <= {arm_reg[CMP_SYNC_STAGES-1:0], 1'b1};
    end
  end

  // One base clock cycle elapses at each rising edge of the base clock.
  assign tick = base_clk_s & ~base_clk_d_reg & arm_reg[CMP_SYNC_STAGES];

  // The window closes on its last tick unless a new write restarts it.
  assign finish = (state_reg == VCC_RUN) && tick && (tick_cnt_reg == LAST_TICK)
                  && !CTRL_WR_STB;

  // Next state and tick count of the comparison window.
  always_comb begin
    state_next    = state_reg;
    tick_cnt_next = tick_cnt_reg;
    if (CTRL_WR_STB) begin
      state_next    = VCC_RUN;
      tick_cnt_next = '0;
    end else begin
      unique case (state_reg)
        VCC_IDLE: begin
          tick_cnt_next = '0;
        end
        VCC_RUN: begin
          if (finish) begin
            state_next    = VCC_IDLE;
            tick_cnt_next = '0;
          end else if (tick) begin
            tick_cnt_next = tick_cnt_reg + CMP_CNT_W'(1);
          end
        end
        default: begin
          state_next    = VCC_IDLE;
          tick_cnt_next = '0;
        end
      endcase
    end
  end

  // State and counter registers.
  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      state_reg    <= VCC_IDLE;
      tick_cnt_reg <= '0;
    end else begin
      state_reg    <= state_next;
      tick_cnt_reg <= tick_cnt_next;
    end
  end

  // The decision is taken only when the window closes; otherwise it holds.
  assign result_next = finish ? decision_s : result_reg;

  // Result bit, cleared by reset.
  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      result_reg <= 1'b0;
    end else begin
      result_reg <= result_next;
    end
  end

  // Read data register: fixed upper bits and the result in bit 0.
  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      CTRL_RDATA <= CMP_RESET_VALUE;
    end else begin
      CTRL_RDATA <= {CMP_UPPER_BITS, result_next};
    end
  end

  // The analog stage is enabled only while a window is open.
  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      COMPARE_ENABLE <= 1'b0;
    end else begin
      COMPARE_ENABLE <= (state_next == VCC_RUN);
    end
  end

  // A write always opens a fresh window with a cleared count.
  start_on_write_a: assert property (
    @(posedge CORE_CLK) disable iff (RESET)
    CTRL_WR_STB |=> (state_reg == VCC_RUN) && (tick_cnt_reg == '0) && COMPARE_ENABLE
  ) else $error("write did not start a comparison");

  // The window closes exactly on the sixth tick after the write.
  six_tick_close_a: assert property (
    @(posedge CORE_CLK) disable iff (RESET)
    $fell(COMPARE_ENABLE) |-> $past(tick) && ($past(tick_cnt_reg) == LAST_TICK)
  ) else $error("window closed at the wrong tick");

  // After closing, the comparator stays idle until the next write.
  idle_until_write_a: assert property (
    @(posedge CORE_CLK) disable iff (RESET)
    (state_reg == VCC_IDLE) && !CTRL_WR_STB |=> (state_reg == VCC_IDLE) && !COMPARE_ENABLE
  ) else $error("comparator left idle without a write");

  // The latched value follows the synchronised decision.
  result_polarity_a: assert property (
    @(posedge CORE_CLK) disable iff (RESET)
    finish |=> (result_reg == $past(decision_s))
      && (CTRL_RDATA[CMP_RESULT_BIT] == $past(decision_s))
  ) else $error("latched result does not match comparator decision");

  // Read data shows the result at bit 0 with the upper bits set.
  read_layout_a: assert property (
    @(posedge CORE_CLK) disable iff (RESET)
    ##1 CTRL_RDATA == {CMP_UPPER_BITS, result_reg}
  ) else $error("read data layout is wrong");

  // Outside the closing cycle the result never changes.
  hold_result_a: assert property (
    @(posedge CORE_CLK) disable iff (RESET)
    !finish |=> $stable(result_reg)
  ) else $error("result changed before the window closed");

  // Right after reset the register reads its reset value with result 0.
  reset_value_a: assert property (
    @(posedge CORE_CLK)
    $past(RESET) && !RESET |-> (CTRL_RDATA == CMP_RESET_VALUE) && !result_reg
  ) else $error("reset value is wrong");

  // A write inside a running window restarts the count.
  restart_window_a: assert property (
    @(posedge CORE_CLK) disable iff (RESET)
    (state_reg == VCC_RUN) && CTRL_WR_STB |=> (tick_cnt_reg == '0)
      && (state_reg == VCC_RUN) && $stable(result_reg)
  ) else $error("write during a window did not restart it");

  // While a window is open the analog stage stays enabled until the closing cycle.
  window_hold_a: assert property (
    @(posedge CORE_CLK) disable iff (RESET)
    (state_reg == VCC_RUN) && !finish |=> COMPARE_ENABLE
  ) else $error("comparator stopped before its window closed");

  // The tick count never passes the closing value.
  count_bound_a: assert property (
    @(posedge CORE_CLK) disable iff (RESET)
    (state_reg == VCC_RUN) |-> (tick_cnt_reg <= LAST_TICK)
  ) else $error("tick count ran past the window length");

  // The count moves only on a base clock tick or a write.
  count_step_a: assert property (
    @(posedge CORE_CLK) disable iff (RESET)
    (state_reg == VCC_RUN) && !tick && !CTRL_WR_STB |=> (state_reg == VCC_RUN)
      && $stable(tick_cnt_reg)
  ) else $error("tick count moved without a base clock tick");

  // The stage stops in the same cycle that the decision lands in the read data.
  close_latch_a: assert property (
    @(posedge CORE_CLK) disable iff (RESET)
    $fell(COMPARE_ENABLE) |-> (CTRL_RDATA[CMP_RESULT_BIT] == $past(decision_s))
  ) else $error("comparator stopped without latching its decision");

  // A read outside the closing cycle leaves the read data unchanged.
  read_hold_a: assert property (
    @(posedge CORE_CLK) disable iff (RESET)
    CTRL_RD_STB && !finish |=> $stable(CTRL_RDATA)
  ) else $error("read changed the register contents");

endmodule

// ===== bench/vcc_analog_model.sv
// Behavioural model of the analog comparator stage.
// Assumes the bench sets both pin levels as plain codes.
`timescale 1ns/1ns
module vcc_analog_model (
  // Pin levels.
  input  wire logic [7:0] analog_in,
  input  wire logic [7:0] reference_in,
  // Control side.
  input  wire logic       enable,
  output logic            decision
);
  logic junk = 1'b0;
  // An idle stage gives no valid answer, so its output wanders.
  always #3 junk = ~junk;
  // Both pins are sensed as high-impedance inputs; 1 means input above reference.
  assign decision = enable ? (analog_in > reference_in) : junk;
endmodule

// ===== bench/tb.sv
// Self-checking bench for the comparator control logic.
// Assumes a free-running base clock and the analog model beside the design.
`timescale 1ns/1ns
module tb;
  import vcc_pkg::*;
  logic        core_clk = 0, reset = 1, wr = 0, rd = 0, base = 0, en_d = 0;
  logic        enable, dec;
  logic [3:0]  wdata = 4'h0, rdata;
  logic [7:0]  vin = 8'h00, vref = 8'h00;
  logic [31:0] seed = 32'h00000055;
  int          n_mismatch = 0, checks = 0, edges = 0;
  logic [3:0]  notes[$];

  // Core clock and an unrelated slow base clock.
  initial forever #2 core_clk = ~core_clk;
  initial forever #21 base = ~base;
  always @(posedge base) edges++;

  vcc_top u_vcc_top (.CORE_CLK(core_clk), .RESET(reset), .CTRL_WR_STB(wr),
    .CTRL_WDATA(wdata), .CTRL_RD_STB(rd), .CTRL_RDATA(rdata),
    .LOW_SPEED_BASE_CLK(base), .COMPARE_DECISION(dec), .COMPARE_ENABLE(enable));
  vcc_analog_model u_vcc_analog_model (.analog_in(vin), .reference_in(vref),
    .enable(enable), .decision(dec));

  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction

  task automatic cmp4(input logic [3:0] got, input logic [3:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic tally_and_finish;
    if (notes.size() != 0) n_mismatch++;
    $display("checks=%0d mismatches=%0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // New random pin levels, never equal.
  task automatic pick(output logic exp_bit);
    seed = xs(seed);
    vin = seed[7:0];
    vref = seed[15:8];
    if (vin == vref) vin = vref ^ 8'h01;
    exp_bit = vin > vref;
  endtask

  // One write strobe, placed well clear of a base clock edge.
  task automatic start(input logic [3:0] d);
    @(posedge base);
    repeat (5) @(posedge core_clk);
    #1 wr = 1;
    wdata = d;
    edges = 0;
    @(posedge core_clk);
    #1 wr = 0;
  endtask

  task automatic rd_chk(input logic [3:0] exp);
    @(posedge core_clk);
    #1 rd = 1;
    cmp4(rdata, exp, "read");
    @(posedge core_clk);
    #1 rd = 0;
  endtask

  task automatic wait_idle;
    int i;
    for (i = 0; i < 200 && enable !== 1'b0; i++) @(posedge core_clk);
    if (enable !== 1'b0) begin
      n_mismatch++;
      tally_and_finish();
    end
  endtask

  // When a window closes, the oldest note is compared with the result.
  always @(negedge core_clk) begin
    en_d <= enable;
    if (en_d === 1'b1 && enable === 1'b0 && notes.size() > 0) begin
      cmp4(rdata, notes.pop_front(), "result");
      cmp4(4'(edges), 4'(CMP_WINDOW_TICKS), "ticks");
    end
  end

  // Reset, then a series of comparisons, one of them restarted midway.
  initial begin
    logic b;
    logic prev;
    prev = 0;
    repeat (12) @(posedge core_clk);
    #1 reset = 0;
    rd_chk(CMP_RESET_VALUE);
    for (int k = 0; k < 8; k++) begin
      pick(b);
      start(seed[19:16]);
      notes.push_back({3'h7, b});
      cmp4({3'h0, enable}, 4'h1, "open");
      if (k == 3) begin
        repeat (3) @(posedge base);
        pick(b);
        start(seed[19:16]);
        notes[0] = {3'h7, b};
      end
      repeat (2) @(posedge base);
      rd_chk({3'h7, prev});
      wait_idle();
      prev = b;
    end
    repeat (8) @(posedge base);
    cmp4({3'h0, enable}, 4'h0, "idle");
    rd_chk({3'h7, prev});
    tally_and_finish();
  end
endmodule
